//--- rtl/rsb_params.svh
// Purpose: Constants of the radio status register bank.
// Assumes: Serial access header is {read, burst, addr[5:0]}.
// Notes: Offsets are the six address bits of the access header.
// Contract
// - Timer high byte reads at 0x36.
// - Timer low byte reads at 0x37.
// - Checksum match bit, cleared entering receive.
// - Carrier sense bit, cleared in idle.
// - Preamble quality bit held until receive re-entry.
// - Preamble quality bit cleared below threshold.
// - Frame flag set on sync, cleared at end.
// - Frame flag cleared on discard or overflow.
// - Frame flag reads zero while transmitting.
// - Bit 0 shows uninverted general output 0.
// - 0x3A holds underflow and transmit count.
// - 0x3B holds overflow and receive count.
// - 0x3C/0x3D hold oscillator calibration results.
// - 0x39 shows PLL calibration setting.
// - 0x35 shows radio state code.
`ifndef RSB_PARAMS_SVH
`define RSB_PARAMS_SVH

// Access header fields.
`define RSB_HDR_READ_BIT 7
`define RSB_HDR_BURST_BIT 6
`define RSB_HDR_ADDR_MSB 5

// Register offsets.
`define RSB_OFS_STATUS_LO 6'h30
`define RSB_OFS_STATUS_HI 6'h3d
`define RSB_OFS_FSM_STATE 6'h35
`define RSB_OFS_TIMER_HIGH 6'h36
`define RSB_OFS_TIMER_LOW 6'h37
`define RSB_OFS_PKT_STATUS 6'h38
`define RSB_OFS_PLL_CAL 6'h39
`define RSB_OFS_TX_LEVEL 6'h3a
`define RSB_OFS_RX_LEVEL 6'h3b
`define RSB_OFS_RC_CAL_A 6'h3c
`define RSB_OFS_RC_CAL_B 6'h3d

// Packet status bit positions.
`define RSB_PKT_CRC_BIT 7
`define RSB_PKT_CS_BIT 6
`define RSB_PKT_QUAL_BIT 5
`define RSB_PKT_CLEAR_BIT 4
`define RSB_PKT_FRAME_BIT 3
`define RSB_PKT_GO2_BIT 2
`define RSB_PKT_GO0_BIT 0

// Queue level fields.
`define RSB_LVL_FLAG_BIT 7

// Reset values.
`define RSB_RST_BYTE 8'h00
`define RSB_RST_STATE 5'h00

`endif

//--- rtl/rsb_pkg.sv
// Purpose: Types of the radio status register bank.
// Assumes: State codes are five bits wide.
// Notes: Only the sleep code, the idle code and codes that the flag logic tests are named.
package rsb_pkg;

    // Radio control state codes that the status flags react to, and the sleep code.
    typedef enum logic [4:0] {
        RSB_ST_SLEEP = 5'b00000,
        RSB_ST_IDLE = 5'b00001,
        RSB_ST_RX = 5'b01101,
        RSB_ST_RX_END = 5'b01110,
        RSB_ST_RX_RST = 5'b01111,
        RSB_ST_RX_OVERFLOW = 5'b10001,
        RSB_ST_TX = 5'b10011,
        RSB_ST_TX_END = 5'b10100
    } rsb_radio_state_e;

    typedef logic [7:0] rsb_byte_t;
    typedef logic [5:0] rsb_addr_t;

endpackage

//--- rtl/rsb_serial_port.sv
// Purpose: Serial register port, mode 0, most significant bit first.
// Assumes: Select, clock and data pins are synchronous to clk_in.
// Notes: Serial clock half period must span at least two clk_in cycles.
`timescale 1ns/1ps
`default_nettype none
`include "rsb_params.svh"
module rsb_serial_port
    import rsb_pkg::*;
(
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic select_n_in,
    input wire logic sclk_in,
    input wire logic mosi_in,
    input wire logic load_in,
    input wire rsb_byte_t tx_byte_in,
    output logic byte_done_out,
    output rsb_byte_t rx_byte_out,
    output logic first_byte_out,
    output logic miso_out,
    output logic miso_oe_n_out
);

    logic sclk_q_r;
    logic [2:0] bit_cnt_r;
    rsb_byte_t shift_in_r;
    rsb_byte_t shift_out_r;
    logic first_r;
    logic rise;
    logic fall;

    // Serial clock edges against the previous sample.
    assign rise = sclk_in & ~sclk_q_r;
    assign fall = ~sclk_in & sclk_q_r;

    // Receive shifter and byte framing.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sclk_q_r <= 1'b0;
            bit_cnt_r <= 3'h0;
            shift_in_r <= `RSB_RST_BYTE;
            byte_done_out <= 1'b0;
            rx_byte_out <= `RSB_RST_BYTE;
            first_byte_out <= 1'b0;
            first_r <= 1'b1;
        end else begin
            sclk_q_r <= sclk_in;
            byte_done_out <= 1'b0;
            if (select_n_in) begin
                bit_cnt_r <= 3'h0;
                first_r <= 1'b1;
            end else if (rise) begin
                shift_in_r <= {shift_in_r[6:0], mosi_in};
                bit_cnt_r <= bit_cnt_r + 3'h1;
                if (bit_cnt_r == 3'h7) begin
                    byte_done_out <= 1'b1;
                    rx_byte_out <= {shift_in_r[6:0], mosi_in};
                    first_byte_out <= first_r;
                    first_r <= 1'b0;
                end
            end
        end
    end

    // Transmit shifter; bits change on the falling serial clock edge.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            shift_out_r <= `RSB_RST_BYTE;
            miso_out <= 1'b0;
            miso_oe_n_out <= 1'b1;
        end else if (select_n_in) begin
            shift_out_r <= `RSB_RST_BYTE;
            miso_out <= 1'b0;
            miso_oe_n_out <= 1'b1;
        end else begin
            miso_oe_n_out <= 1'b0;
            if (load_in) begin
                shift_out_r <= tx_byte_in;
            end else if (fall) begin
                miso_out <= shift_out_r[7];
                shift_out_r <= {shift_out_r[6:0], 1'b0};
            end
        end
    end

endmodule // rsb_serial_port
`default_nettype wire

//--- rtl/rsb_frame_flags.sv
// Purpose: Sticky packet flags driven by radio state and receive events.
// Assumes: Event inputs are one-cycle pulses from the receiver.
// Notes: A set in the same cycle as a clear wins.
`timescale 1ns/1ps
`default_nettype none
`include "rsb_params.svh"
module rsb_frame_flags
    import rsb_pkg::*;
(
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic [4:0] radio_state_in,
    input wire logic crc_done_in,
    input wire logic crc_match_in,
    input wire logic quality_hit_in,
    input wire logic [7:0] quality_in,
    input wire logic [7:0] threshold_in,
    input wire logic sync_found_in,
    input wire logic packet_end_in,
    input wire logic filter_discard_in,
    output logic crc_match_out,
    output logic quality_reached_out,
    output logic frame_flag_out
);

    logic [4:0] prev_state_r;
    logic in_rx;
    logic in_tx;
    logic rx_entry;
    logic rx_restart;

    // Receive family and entry detection.
    assign in_rx = (radio_state_in == RSB_ST_RX) || (radio_state_in == RSB_ST_RX_END)
        || (radio_state_in == RSB_ST_RX_RST);
    assign in_tx = (radio_state_in == RSB_ST_TX) || (radio_state_in == RSB_ST_TX_END);
    assign rx_entry = (radio_state_in == RSB_ST_RX) && (prev_state_r != RSB_ST_RX);
    assign rx_restart = (radio_state_in == RSB_ST_RX_RST) && (prev_state_r != RSB_ST_RX_RST);

    // Previous state code.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            prev_state_r <= `RSB_RST_STATE;
        end else begin
            prev_state_r <= radio_state_in;
        end
    end

    // Checksum match flag.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            crc_match_out <= 1'b0;
        end else if (crc_done_in) begin
            crc_match_out <= crc_match_in;
        end else if (rx_entry || rx_restart) begin
            crc_match_out <= 1'b0;
        end
    end

    // Preamble quality flag; outside receive it holds its value.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            quality_reached_out <= 1'b0;
        end else if (quality_hit_in && in_rx) begin
            quality_reached_out <= 1'b1;
        end else if (rx_entry) begin
            quality_reached_out <= 1'b0;
        end else if (in_rx && (quality_in < threshold_in)) begin
            quality_reached_out <= 1'b0;
        end
    end

    // Start of frame flag.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            frame_flag_out <= 1'b0;
        end else if (in_tx) begin
            frame_flag_out <= 1'b0;
        end else if (sync_found_in && in_rx) begin
            frame_flag_out <= 1'b1;
        end else if (packet_end_in || filter_discard_in) begin
            frame_flag_out <= 1'b0;
        end else if (radio_state_in == RSB_ST_RX_OVERFLOW) begin
            frame_flag_out <= 1'b0;
        end
    end

endmodule // rsb_frame_flags
`default_nettype wire

//--- rtl/rsb_status_bank.sv
// Purpose: Read-only status register bank behind the serial register port.
// Assumes: All status inputs are synchronous to clk_in, 20 MHz.
// Notes: Status values are sampled each cycle and frozen when a byte is loaded.
`timescale 1ns/1ps
`default_nettype none
`include "rsb_params.svh"
module rsb_status_bank
    import rsb_pkg::*;
(
    input wire logic clk_in,
    input wire logic resetn_in,
    // Serial register port.
    input wire logic select_n_in,
    input wire logic sclk_in,
    input wire logic mosi_in,
    output logic miso_out,
    output logic miso_oe_n_out,
    // Radio control state.
    input wire logic [4:0] radio_fsm_state_in,
    // Wake-on-radio timer.
    input wire logic [15:0] wakeup_timer_in,
    // Receive events and levels.
    input wire logic crc_done_in,
    input wire logic crc_match_in,
    input wire logic carrier_sense_in,
    input wire logic preamble_hit_in,
    input wire logic [7:0] preamble_quality_indicator_in,
    input wire logic [7:0] preamble_quality_threshold_in,
    input wire logic channel_clear_in,
    input wire logic sync_found_in,
    input wire logic packet_end_in,
    input wire logic filter_discard_in,
    // General outputs before polarity inversion.
    input wire logic general_output_2_in,
    input wire logic general_output_0_in,
    // Queue levels.
    input wire logic tx_queue_underflow_in,
    input wire logic [6:0] tx_byte_count_in,
    input wire logic rx_queue_overflow_in,
    input wire logic [6:0] rx_byte_count_in,
    // Calibration results.
    input wire logic [7:0] pll_cal_setting_in,
    input wire logic [6:0] rc_osc_cal_result_a_in,
    input wire logic [6:0] rc_osc_cal_result_b_in
);

    logic byte_done;
    rsb_byte_t rx_byte;
    logic first_byte;
    logic load;
    rsb_byte_t tx_byte;
    rsb_byte_t read_data;

    logic crc_match;
    logic quality_reached;
    logic frame_flag;

    logic [4:0] fsm_state_r;
    logic [15:0] timer_r;
    logic carrier_sense_r;
    logic channel_clear_r;
    logic go2_r;
    logic go0_r;
    logic tx_underflow_r;
    logic [6:0] tx_count_r;
    logic rx_overflow_r;
    logic [6:0] rx_count_r;
    logic [7:0] pll_cal_r;
    logic [6:0] rc_a_r;
    logic [6:0] rc_b_r;

    rsb_byte_t hdr_r;
    logic hdr_valid_r;
    logic hdr_status_read;
    logic byte_is_status_read;
    rsb_addr_t read_addr;

    rsb_byte_t pkt_status;

    // Serial shifter for the access header and data bytes.
    rsb_serial_port u_port (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .select_n_in(select_n_in),
        .sclk_in(sclk_in),
        .mosi_in(mosi_in),
        .load_in(load),
        .tx_byte_in(tx_byte),
        .byte_done_out(byte_done),
        .rx_byte_out(rx_byte),
        .first_byte_out(first_byte),
        .miso_out(miso_out),
        .miso_oe_n_out(miso_oe_n_out)
    );

    // Sticky packet flags.
    rsb_frame_flags u_flags (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .radio_state_in(radio_fsm_state_in),
        .crc_done_in(crc_done_in),
        .crc_match_in(crc_match_in),
        .quality_hit_in(preamble_hit_in),
        .quality_in(preamble_quality_indicator_in),
        .threshold_in(preamble_quality_threshold_in),
        .sync_found_in(sync_found_in),
        .packet_end_in(packet_end_in),
        .filter_discard_in(filter_discard_in),
        .crc_match_out(crc_match),
        .quality_reached_out(quality_reached),
        .frame_flag_out(frame_flag)
    );

    // Radio state and timer samples.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            fsm_state_r <= `RSB_RST_STATE;
            timer_r <= 16'h0000;
        end else begin
            fsm_state_r <= radio_fsm_state_in;
            timer_r <= wakeup_timer_in;
        end
    end

    // Live level samples; carrier sense is forced low in idle.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            carrier_sense_r <= 1'b0;
            channel_clear_r <= 1'b0;
            go2_r <= 1'b0;
            go0_r <= 1'b0;
        end else begin
            if (radio_fsm_state_in == RSB_ST_IDLE) begin
                carrier_sense_r <= 1'b0;
            end else begin
                carrier_sense_r <= carrier_sense_in;
            end
            channel_clear_r <= channel_clear_in;
            go2_r <= general_output_2_in;
            go0_r <= general_output_0_in;
        end
    end

    // Queue level samples.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tx_underflow_r <= 1'b0;
            tx_count_r <= 7'h00;
            rx_overflow_r <= 1'b0;
            rx_count_r <= 7'h00;
        end else begin
            tx_underflow_r <= tx_queue_underflow_in;
            tx_count_r <= tx_byte_count_in;
            rx_overflow_r <= rx_queue_overflow_in;
            rx_count_r <= rx_byte_count_in;
        end
    end

    // Calibration samples.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pll_cal_r <= `RSB_RST_BYTE;
            rc_a_r <= 7'h00;
            rc_b_r <= 7'h00;
        end else begin
            pll_cal_r <= pll_cal_setting_in;
            rc_a_r <= rc_osc_cal_result_a_in;
            rc_b_r <= rc_osc_cal_result_b_in;
        end
    end

    // Packet status byte; bit 1 stays zero.
    always_comb begin
        pkt_status = `RSB_RST_BYTE;
        pkt_status[`RSB_PKT_CRC_BIT] = crc_match;
        pkt_status[`RSB_PKT_CS_BIT] = carrier_sense_r;
        pkt_status[`RSB_PKT_QUAL_BIT] = quality_reached;
        pkt_status[`RSB_PKT_CLEAR_BIT] = channel_clear_r;
        pkt_status[`RSB_PKT_FRAME_BIT] = frame_flag;
        pkt_status[`RSB_PKT_GO2_BIT] = go2_r;
        pkt_status[`RSB_PKT_GO0_BIT] = go0_r;
    end

    // Read multiplexer; unmapped offsets and unused bits read as zero.
    always_comb begin
        read_data = `RSB_RST_BYTE;
        unique case (read_addr)
            `RSB_OFS_FSM_STATE: read_data = {3'h0, fsm_state_r};
            `RSB_OFS_TIMER_HIGH: read_data = timer_r[15:8];
            `RSB_OFS_TIMER_LOW: read_data = timer_r[7:0];
            `RSB_OFS_PKT_STATUS: read_data = pkt_status;
            `RSB_OFS_PLL_CAL: read_data = pll_cal_r;
            `RSB_OFS_TX_LEVEL: read_data = {tx_underflow_r, tx_count_r};
            `RSB_OFS_RX_LEVEL: read_data = {rx_overflow_r, rx_count_r};
            `RSB_OFS_RC_CAL_A: read_data = {1'b0, rc_a_r};
            `RSB_OFS_RC_CAL_B: read_data = {1'b0, rc_b_r};
            default: read_data = `RSB_RST_BYTE;
        endcase
    end

    // Header latch; cleared when the select line rises.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            hdr_r <= `RSB_RST_BYTE;
            hdr_valid_r <= 1'b0;
        end else if (select_n_in) begin
            hdr_valid_r <= 1'b0;
        end else if (byte_done && first_byte) begin
            hdr_r <= rx_byte;
            hdr_valid_r <= 1'b1;
        end
    end

    // A status read needs both the read and burst bits in the header.
    function automatic logic is_status_read(input rsb_byte_t hdr);
        is_status_read = hdr[`RSB_HDR_READ_BIT] && hdr[`RSB_HDR_BURST_BIT]
            && (hdr[`RSB_HDR_ADDR_MSB:0] >= `RSB_OFS_STATUS_LO)
            && (hdr[`RSB_HDR_ADDR_MSB:0] <= `RSB_OFS_STATUS_HI);
    endfunction

    // Addressing of the byte that follows the header or a data byte.
    assign hdr_status_read = hdr_valid_r && is_status_read(hdr_r);
    assign byte_is_status_read = first_byte ? is_status_read(rx_byte) : hdr_status_read;
    assign read_addr = first_byte ? rx_byte[`RSB_HDR_ADDR_MSB:0]
        : hdr_r[`RSB_HDR_ADDR_MSB:0];

    // Each completed byte loads the next outgoing byte; writes store nothing.
    assign load = byte_done;
    assign tx_byte = byte_is_status_read ? read_data : `RSB_RST_BYTE;

endmodule // rsb_status_bank
`default_nettype wire

//--- bench/rsb_status_bank_asserts.sv
// Purpose: Checks on the serial side of the status bank.
// Assumes: Mode 0 frames, header first, host samples miso on sclk rise.
// Notes: Helper logic decodes the header and the bit position.
`timescale 1ns/1ps
`default_nettype none
module rsb_status_bank_asserts (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic select_n_in,
    input wire logic sclk_in,
    input wire logic mosi_in,
    input wire logic miso_out,
    input wire logic miso_oe_n_out
);
    logic sclk_q;
    logic [5:0] nbit;
    logic [7:0] hdr;
    logic rise;
    logic bad;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);
    // A host sampling point and a header that must be refused.
    assign rise = sclk_in && !sclk_q && !select_n_in;
    assign bad = hdr[7:6] != 2'b11 || hdr[5:0] < 6'h35 || hdr[5:0] > 6'h3d;
    // Tracks bit position and header within a frame.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sclk_q <= 1'b0;
            nbit <= 6'h00;
            hdr <= 8'h00;
        end else begin
            sclk_q <= sclk_in;
            if (select_n_in) begin
                nbit <= 6'h00;
            end else if (rise) begin
                nbit <= nbit + {5'h00, nbit != 6'h3f};
                if (nbit < 6'h08) begin
                    hdr <= {hdr[6:0], mosi_in};
                end
            end
        end
    end
    chk_idle_miso_low: assert property (select_n_in && $past(select_n_in) |-> !miso_out)
        else $error("miso not low while deselected");
    chk_oe_while_sel: assert property (!select_n_in [*2] |-> !miso_oe_n_out)
        else $error("miso not enabled in frame");
    chk_miso_on_fall: assert property ($changed(miso_out) && !select_n_in
        && !$past(select_n_in) |-> !$past(sclk_in) || !$past(sclk_in, 2))
        else $error("miso changed away from a falling sclk");
    chk_hdr_silent: assert property (rise && nbit < 6'h08 |-> !miso_out)
        else $error("header byte returned data");
    chk_refused_zero: assert property (rise && nbit >= 6'h08 && bad |-> !miso_out)
        else $error("refused access returned data");
    chk_state_pad: assert property (rise && nbit >= 6'h08 && hdr == 8'hf5
        && nbit[2:0] < 3'h3 |-> !miso_out)
        else $error("state byte upper bits set");
    chk_pkt_spare: assert property (rise && nbit >= 6'h08 && hdr == 8'hf8
        && nbit[2:0] == 3'h6 |-> !miso_out)
        else $error("packet status bit 1 set");
    chk_cal_pad: assert property (rise && nbit >= 6'h08 && hdr[7:1] == 7'h7e
        && nbit[2:0] == 3'h0 |-> !miso_out)
        else $error("calibration byte bit 7 set");
    cov_pkt_read: cover property (rise && hdr == 8'hf8 && nbit == 6'h0f);
    cov_refused: cover property (rise && bad && nbit == 6'h08);
    cov_burst_two: cover property (rise && hdr == 8'hf6 && nbit == 6'h17);
endmodule // rsb_status_bank_asserts
`default_nettype wire

//--- bench/rsb_host_model.sv
// Purpose: Host controller on the serial register port.
// Assumes: Mode 0, most significant bit first, pins change at clk_in falls.
// Notes: Serial clock stands low between frames; mosi inverts when idle.
`timescale 1ns/1ps
`default_nettype none
module rsb_host_model (
    input wire logic clk_in,
    input wire logic miso_in,
    output logic select_n_out,
    output logic sclk_out,
    output logic mosi_out
);
    // Idle pin levels.
    initial begin
        select_n_out = 1'b1;
        sclk_out = 1'b0;
        mosi_out = 1'b0;
    end
    // One frame of a header and nb bytes of wd; half sets each sclk phase in clocks.
    // Lock status is never polled through the general output bits.
    task automatic xfer(input logic [7:0] hdr, input int nb, input int half,
                        input logic [7:0] wd, output logic [15:0] rd);
        logic [23:0] s;
        s = {hdr, wd, wd};
        rd = 16'h0000;
        @(negedge clk_in);
        select_n_out <= 1'b0;
        mosi_out <= s[23];
        for (int j = 0; j < 8 * (nb + 1); j++) begin
            repeat (half) @(negedge clk_in);
            sclk_out <= 1'b1;
            repeat (half) @(negedge clk_in);
            if (j >= 8) begin
                rd = {rd[14:0], miso_in};
            end
            sclk_out <= 1'b0;
            s = {s[22:0], 1'b0};
            mosi_out <= (j + 1 < 8 * (nb + 1)) ? s[23] : ~mosi_out;
        end
        repeat (half) @(negedge clk_in);
        select_n_out <= 1'b1;
        repeat (2) @(negedge clk_in);
    endtask
endmodule // rsb_host_model
`default_nettype wire

//--- bench/testbench.sv
// Purpose: Self-checking bench of the radio status register bank.
// Assumes: Inputs change at clk_in falls; status held steady during reads.
// Notes: A flag model tracks sticky bits from the events it pulses.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module testbench;
    import rsb_pkg::*;
    logic clk_in, resetn_in, select_n, sclk, mosi, miso, miso_oe_n, miso_w;
    logic [4:0] st, ev;
    logic [15:0] tmr, rd;
    logic crc_m, cs, clr, go2, go0, tuf, rov;
    logic [7:0] qual, qual_th, pll;
    logic [6:0] tcnt, rcnt, rca, rcb;
    logic [31:0] seed, r;
    bit crc_e, qual_e, frame_e;
    int mismatches, n_tests;
    logic [7:0] bad_h [5] = '{8'h78, 8'hb8, 8'hf1, 8'hfe, 8'h38};
    // Released miso shows the inverse of its last level.
    assign miso_w = miso_oe_n ? ~miso : miso;
    rsb_status_bank u_dut (.clk_in(clk_in), .resetn_in(resetn_in), .select_n_in(select_n),
        .sclk_in(sclk), .mosi_in(mosi), .miso_out(miso), .miso_oe_n_out(miso_oe_n),
        .radio_fsm_state_in(st), .wakeup_timer_in(tmr), .crc_done_in(ev[4]),
        .crc_match_in(crc_m), .carrier_sense_in(cs), .preamble_hit_in(ev[3]),
        .preamble_quality_indicator_in(qual), .preamble_quality_threshold_in(qual_th),
        .channel_clear_in(clr), .sync_found_in(ev[2]), .packet_end_in(ev[1]),
        .filter_discard_in(ev[0]), .general_output_2_in(go2), .general_output_0_in(go0),
        .tx_queue_underflow_in(tuf), .tx_byte_count_in(tcnt), .rx_queue_overflow_in(rov),
        .rx_byte_count_in(rcnt), .pll_cal_setting_in(pll), .rc_osc_cal_result_a_in(rca),
        .rc_osc_cal_result_b_in(rcb));
    rsb_host_model u_host (.clk_in(clk_in), .miso_in(miso_w), .select_n_out(select_n),
        .sclk_out(sclk), .mosi_out(mosi));
    // Clock at 20 MHz.
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end
    // Random source.
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Expected status byte from the held inputs and the flag model.
    function automatic logic [7:0] exp_byte(input logic [5:0] a);
        case (a)
            6'h35: return {3'b000, st};
            6'h36: return tmr[15:8];
            6'h37: return tmr[7:0];
            6'h38: return {crc_e, cs && st != 5'h01, qual_e, clr,
                           frame_e && st != 5'h13 && st != 5'h14, go2, 1'b0, go0};
            6'h39: return pll;
            6'h3a: return {tuf, tcnt};
            6'h3b: return {rov, rcnt};
            6'h3c: return {1'b0, rca};
            6'h3d: return {1'b0, rcb};
            default: return 8'h00;
        endcase
    endfunction
    // Reads one status byte and compares it with the model.
    task automatic rd_chk(input logic [5:0] a, input int half);
        u_host.xfer({2'b11, a}, 1, half, 8'h00, rd);
        `CHK(rd[7:0], exp_byte(a))
    endtask
    // Moves the radio state and applies entry clears to the model.
    task automatic go(input logic [4:0] s);
        @(negedge clk_in);
        if (s != st && (s == 5'h0d || s == 5'h0f)) crc_e = 1'b0;
        if (s != st && s == 5'h0d) qual_e = 1'b0;
        if (s == 5'h11) frame_e = 1'b0;
        st <= s;
    endtask
    // Pulses events {crc_done, pqt_hit, sync, end, discard} for one cycle.
    task automatic pulse(input logic [4:0] m);
        @(negedge clk_in);
        ev <= m;
        @(negedge clk_in);
        ev <= 5'h00;
        if (m[4]) crc_e = crc_m;
        if (m[3] && st >= 5'h0d && st <= 5'h0f) qual_e = 1'b1;
        if (m[1] || m[0]) frame_e = 1'b0;
        if (m[2] && st >= 5'h0d && st <= 5'h0f) frame_e = 1'b1;
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Cuts a hang short.
    initial begin
        repeat (80000) @(posedge clk_in);
        mismatches++;
        $display("wrong value at %0t: run timed out", $time);
        close_out();
    end
    // Main sequence.
    initial begin
        {st, ev, tmr, crc_m, cs, clr, go2, go0, tuf, rov} = '0;
        {pll, tcnt, rcnt, rca, rcb} = '0;
        qual = 8'hff;
        qual_th = 8'h10;
        seed = 32'h30d38808;
        mismatches = 0;
        n_tests = 0;
        resetn_in = 1'b0;
        repeat (16) @(negedge clk_in);
        resetn_in = 1'b1;
        repeat (3) @(negedge clk_in);
        for (int it = 0; it < 6; it++) begin
            r = rnd();
            {rov, tuf, rcnt, tcnt, tmr} = r;
            r = rnd();
            {go0, go2, clr, cs, rcb, rca, pll} = r[25:0];
            go(it == 0 ? 5'h01 : r[30:26]);
            for (int a = 'h35; a <= 'h3d; a++) rd_chk(a[5:0], 2 + it % 2);
        end
        $display("test random levels done");
        go(5'h0d);
        crc_m <= 1'b1;
        pulse(5'h10);
        pulse(5'h08);
        pulse(5'h04);
        rd_chk(6'h38, 2);
        go(5'h13);
        rd_chk(6'h38, 2);
        pulse(5'h02);
        go(5'h01);
        rd_chk(6'h38, 3);
        go(5'h0d);
        rd_chk(6'h38, 2);
        pulse(5'h08);
        qual <= 8'h05;
        qual_e = 1'b0;
        rd_chk(6'h38, 2);
        qual <= 8'hff;
        pulse(5'h04);
        pulse(5'h02);
        rd_chk(6'h38, 2);
        pulse(5'h04);
        pulse(5'h01);
        rd_chk(6'h38, 2);
        pulse(5'h04);
        go(5'h11);
        rd_chk(6'h38, 2);
        pulse(5'h10);
        go(5'h0f);
        rd_chk(6'h38, 2);
        $display("test packet flags done");
        foreach (bad_h[i]) begin
            u_host.xfer(bad_h[i], 1, 2, 8'h5a, rd);
            `CHK(rd[7:0], 8'h00)
        end
        rd_chk(6'h38, 2);
        u_host.xfer(8'hf6, 2, 2, 8'h00, rd);
        `CHK(rd, {2{tmr[15:8]}})
        $display("test refused access done");
        close_out();
    end
endmodule // testbench
bind rsb_status_bank rsb_status_bank_asserts u_chk (.clk_in(clk_in), .resetn_in(resetn_in),
    .select_n_in(select_n_in), .sclk_in(sclk_in), .mosi_in(mosi_in), .miso_out(miso_out),
    .miso_oe_n_out(miso_oe_n_out));
`default_nettype wire
